// file: src/dkwd_pkg.sv
// Purpose: constants and carriers for the double key watchdog block
// Assumes: 8-bit processor I/O space, one system clock
// Notes:   period codes select 2^16..2^22 clock cycles
package dkwd_pkg;
  localparam logic [7:0] DKWD_MASTER_ADDR  = 8'hF0;
  localparam logic [7:0] DKWD_COMMAND_ADDR = 8'hF1;
  localparam logic [7:0] DKWD_KEY_DISABLE  = 8'hB1;
  localparam logic [7:0] DKWD_KEY_CLEAR    = 8'h4E;
  localparam logic [7:0] DKWD_KEY_MODE     = 8'hDB;
  localparam int         DKWD_RUN_POS      = 7;
  localparam int         DKWD_PERIOD_POS   = 5;
  localparam int         DKWD_MODE_POS     = 3;
  localparam logic [2:0] DKWD_FIXED_LOW    = 3'h3;
  localparam logic       DKWD_RUN_RST      = 1'b1;
  localparam logic [1:0] DKWD_PERIOD_RST   = 2'h3;
  localparam logic [1:0] DKWD_MODE_RST     = 2'h3;
  localparam int         DKWD_EXP_BASE     = 16;
  localparam int         DKWD_EXP_STEP     = 2;
  localparam int         DKWD_CNT_W        = 23;

  typedef enum logic [1:0] {
    DKWD_IDLE1 = 2'h0,
    DKWD_IDLE2 = 2'h1,
    DKWD_STOP  = 2'h2,
    DKWD_RUN   = 2'h3
  } dkwd_mode_e;

  typedef struct packed {
    logic       run;
    logic [1:0] period;
    dkwd_mode_e mode;
  } dkwd_ctrl_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dkwd_io_s;
endpackage

// file: src/dkwd_counter.sv
// Purpose: watchdog count with selectable power-of-two terminal
// Assumes: clear and hold come from the register logic on the same clock
// Notes:   a one-cycle pulse marks each expiry, then the count restarts
`timescale 1ns/1ns
module dkwd_counter #(
  parameter int CNT_W = dkwd_pkg::DKWD_CNT_W
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       hold,
  input  wire logic       clear,
  input  wire logic [1:0] period,
  output logic            expire
);
  import dkwd_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             expire_reg;
  logic             expire_next;
  logic [CNT_W-1:0] last;

  // terminal value is 2^(16+2*code)-1
  always_comb begin
    last = (CNT_W'(1) << (DKWD_EXP_BASE + DKWD_EXP_STEP * int'(period))) - CNT_W'(1);
  end

  always_comb begin
    count_next  = count_reg + CNT_W'(1);
    expire_next = 1'b0;
    if (hold || clear) begin
      count_next = '0;
    end else if (count_reg == last) begin
      count_next  = '0;
      expire_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_reg  <= '0;
      expire_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;
endmodule

// file: src/dkwd_top.sv
// Purpose: double key watchdog and power-down mode control registers
// Assumes: processor I/O cycles arrive as one-cycle read/write strobes on ref_clk
// Notes:   timeout_pulse_out is a one-cycle high pulse per expiry
//          a stored run bit of zero does not stop the count by itself
//          the unlock stays open across unknown command codes
`timescale 1ns/1ns

module dkwd_top #(
  parameter int CNT_W = dkwd_pkg::DKWD_CNT_W
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire dkwd_pkg::dkwd_io_s io,
  output logic [7:0]             rdata,
  output logic                   rdata_valid,
  output dkwd_pkg::dkwd_mode_e   power_down_select,
  output logic                   watchdog_active,
  output logic                   timeout_pulse_out
);
  import dkwd_pkg::*;

  // unlock window for the power-down mode field
  typedef enum logic {
    DKWD_KEY_LOCKED = 1'b0,
    DKWD_KEY_OPEN   = 1'b1
  } dkwd_key_e;

  dkwd_ctrl_s ctrl_reg;
  dkwd_ctrl_s ctrl_next;
  logic       active_reg;
  logic       active_next;
  dkwd_key_e  key_reg;
  dkwd_key_e  key_next;
  logic       clear_reg;
  logic       clear_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       wr_master;
  logic       wr_command;
  logic       key_disable;
  logic       key_clear;
  logic       key_mode;
  logic       enable_edge;
  logic       period_change;
  logic       expire;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // low three bits are not stored, they always read back fixed
  function automatic logic [7:0] master_image(input dkwd_ctrl_s ctrl);
    master_image = {ctrl.run, ctrl.period, ctrl.mode, DKWD_FIXED_LOW};
  endfunction

  // bus decode; a read and a write both take effect when both are high
  assign wr_master     = io.wr && hit(io.addr, DKWD_MASTER_ADDR);
  assign wr_command    = io.wr && hit(io.addr, DKWD_COMMAND_ADDR);
  assign key_disable   = wr_command && hit(io.wdata, DKWD_KEY_DISABLE);
  assign key_clear     = wr_command && hit(io.wdata, DKWD_KEY_CLEAR);
  assign key_mode      = wr_command && hit(io.wdata, DKWD_KEY_MODE);
  assign enable_edge   = wr_master && io.wdata[DKWD_RUN_POS] && !active_reg;
  assign period_change = wr_master && (io.wdata[DKWD_PERIOD_POS +: 2] != ctrl_reg.period);

  // master register fields
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_master) begin
      ctrl_next.run    = io.wdata[DKWD_RUN_POS];
      ctrl_next.period = io.wdata[DKWD_PERIOD_POS +: 2];
      // mode field only moves while the unlock is open
      if (key_reg == DKWD_KEY_OPEN) begin
        ctrl_next.mode = dkwd_mode_e'(io.wdata[DKWD_MODE_POS +: 2]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    // reset also pulls the mode field back to run
    if (reset) begin
      ctrl_reg.run    <= DKWD_RUN_RST;
      ctrl_reg.period <= DKWD_PERIOD_RST;
      ctrl_reg.mode   <= dkwd_mode_e'(DKWD_MODE_RST);
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // running state: the stored run bit alone never stops the count
  always_comb begin
    active_next = active_reg;
    // re-enable needs no key; only stopping is guarded
    if (wr_master && io.wdata[DKWD_RUN_POS]) begin
      active_next = 1'b1;
    end else if (key_disable && !ctrl_reg.run) begin
      active_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_reg <= DKWD_RUN_RST;
    end else begin
      active_reg <= active_next;
    end
  end

  // unlock: opened by the mode key, shut by the next master write
  // or by any other defined key, so neither may come between the key and the write
  always_comb begin
    key_next = key_reg;
    unique case (key_reg)
      DKWD_KEY_LOCKED: begin
        if (key_mode) begin
          key_next = DKWD_KEY_OPEN;
        end
      end
      DKWD_KEY_OPEN: begin
        if (wr_master || key_disable || key_clear) begin
          key_next = DKWD_KEY_LOCKED;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      key_reg <= DKWD_KEY_LOCKED;
    end else begin
      key_reg <= key_next;
    end
  end

  // restart is registered so the counter sees settled fields
  always_comb begin
    clear_next = 1'b0;
    if (key_clear) begin
      clear_next = 1'b1;
    end else if (enable_edge || period_change) begin
      clear_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clear_reg <= 1'b0;
    end else begin
      clear_reg <= clear_next;
    end
  end

  // read answer strobe, one cycle after the request
  always_comb begin
    rvalid_next = io.rd;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rvalid_next;
    end
  end

  // read data: command address answers zero, it holds nothing readable
  always_comb begin
    rdata_next = rdata_reg;
    if (io.rd) begin
      rdata_next = 8'h00;
      if (hit(io.addr, DKWD_MASTER_ADDR)) begin
        rdata_next = master_image(ctrl_reg);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // count held at zero while stopped, so a re-enable starts a full period
  dkwd_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .hold    (!active_reg),
    .clear   (clear_reg),
    .period  (ctrl_reg.period),
    .expire  (expire)
  );

  assign timeout_pulse_out = expire;
  assign rdata             = rdata_reg;
  assign rdata_valid       = rvalid_reg;
  assign power_down_select = ctrl_reg.mode;
  assign watchdog_active   = active_reg;
endmodule

// file: test/dkwd_sva.sv
// Purpose: port checks for dkwd_top
// Assumes: one clock, sync reset
// Notes:   bound below
`timescale 1ns/1ns
module dkwd_sva #(
  parameter int CNT_W = dkwd_pkg::DKWD_CNT_W
) (
  input wire logic                 ref_clk,
  input wire logic                 reset,
  input wire dkwd_pkg::dkwd_io_s   io,
  input wire logic [7:0]           rdata,
  input wire logic                 rdata_valid,
  input wire dkwd_pkg::dkwd_mode_e power_down_select,
  input wire logic                 watchdog_active,
  input wire logic                 timeout_pulse_out
);
  import dkwd_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  rd_answer_a: assert property (io.rd && !io.wr |=> rdata_valid)
    else $error("read unanswered");
  fixed_bits_a: assert property (rdata_valid && $past(io.addr) == DKWD_MASTER_ADDR
    |-> rdata[2:0] == DKWD_FIXED_LOW) else $error("low bits wrong");
  cmd_hidden_a: assert property (rdata_valid && $past(io.addr) != DKWD_MASTER_ADDR
    |-> rdata == 8'h00) else $error("command readable");
  reset_state_a: assert property ($past(reset)
    |-> watchdog_active && power_down_select == DKWD_RUN) else $error("reset state");
  pulse_width_a: assert property (timeout_pulse_out |=> !timeout_pulse_out)
    else $error("long pulse");
  stop_key_a: assert property ($fell(watchdog_active) |-> $past(io.wr
    && io.addr == DKWD_COMMAND_ADDR && io.wdata == DKWD_KEY_DISABLE)) else $error("stop");
  mode_key_a: assert property ($changed(power_down_select)
    |-> $past(io.wr && io.addr == DKWD_MASTER_ADDR)) else $error("mode change");
  quiet_off_a: assert property (!watchdog_active [*2] |=> !timeout_pulse_out)
    else $error("pulse while off");
endmodule
bind dkwd_top dkwd_sva #(.CNT_W(CNT_W)) i_dkwd_sva (.ref_clk(ref_clk), .reset(reset),
  .io(io), .rdata(rdata), .rdata_valid(rdata_valid),
  .power_down_select(power_down_select), .watchdog_active(watchdog_active),
  .timeout_pulse_out(timeout_pulse_out));

// file: test/tb.sv
// Purpose: directed bench for dkwd_top
// Assumes: 25 MHz ref_clk
// Notes:   only period code 00 is timed, longer codes cost too many cycles
`timescale 1ns/1ns
module tb;
  import dkwd_pkg::*;
  logic       ref_clk, reset, rdata_valid, watchdog_active, timeout_pulse_out;
  logic [7:0] rdata;
  dkwd_io_s   io;
  dkwd_mode_e power_down_select;
  int         miscompares, comparisons, cycles, n;
  dkwd_top i_dkwd_top (.ref_clk(ref_clk), .reset(reset), .io(io), .rdata(rdata),
    .rdata_valid(rdata_valid), .power_down_select(power_down_select),
    .watchdog_active(watchdog_active), .timeout_pulse_out(timeout_pulse_out));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge ref_clk);
    io <= '0;
    #1;
    if (!w) begin
      chk(rdata_valid, 1'b1);
      chk(rdata, d);
    end
  endtask
  task automatic t_keys();
    acc(0, DKWD_MASTER_ADDR, 8'hFB);
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_DISABLE);
    chk(watchdog_active, 1'b1);
    acc(1, DKWD_MASTER_ADDR, 8'h03);
    acc(1, DKWD_COMMAND_ADDR, 8'h55);
    chk(watchdog_active, 1'b1);
    chk(power_down_select, DKWD_RUN);
    acc(0, DKWD_MASTER_ADDR, 8'h1B);
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_DISABLE);
    chk(watchdog_active, 1'b0);
    acc(0, DKWD_COMMAND_ADDR, 8'h00);
    acc(0, 8'h22, 8'h00);
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_MODE);
      acc(1, DKWD_MASTER_ADDR, {3'h0, m[1:0], DKWD_FIXED_LOW});
      chk(power_down_select, m[1:0]);
    end
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_MODE);
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_CLEAR);
    acc(1, DKWD_MASTER_ADDR, 8'h13);
    chk(power_down_select, DKWD_RUN);
  endtask
  task automatic t_reset();
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_MODE);
    acc(1, DKWD_MASTER_ADDR, 8'h13);
    chk(power_down_select, DKWD_STOP);
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_DISABLE);
    chk(watchdog_active, 1'b0);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    acc(0, DKWD_MASTER_ADDR, 8'hFB);
    chk(watchdog_active, 1'b1);
    chk(power_down_select, DKWD_RUN);
  endtask
  task automatic t_timer();
    acc(1, DKWD_MASTER_ADDR, 8'h9B);
    chk(watchdog_active, 1'b1);
    // clear lands before the first expiry would, so a late pulse proves it
    repeat (30000) begin
      @(posedge ref_clk);
      #1;
      if (timeout_pulse_out !== 1'b0)
        chk(timeout_pulse_out, 1'b0);
    end
    acc(1, DKWD_COMMAND_ADDR, DKWD_KEY_CLEAR);
    while (timeout_pulse_out !== 1'b1 && n < 70000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n > 65525 && n < 65545, 1'b1);
  endtask
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 99000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    io = '0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_keys();
    t_mode();
    t_timer();
    t_reset();
    summarize();
  end
endmodule
